// *** logic/pts_pkg.sv ***
// Purpose: Shared constants and types for the paged time switch scheduler
// Assumes: Decoded page messages arrive as one struct per valid pulse
// Notes:   Function list follows
// Function
// - Store seven-day default plan, 24 relay steps
// - Run default plan on arrival or expiry
// - New default plan overwrites, runs at once
// - Alternate week plan outranks default until expiry
// - Delivered alternate plan starts immediately
// - One-day override plan outranks both week plans
// - Delivered override plan starts immediately
// - Override ends midnight or cancel, restores plan
// - Time-set page loads day, hour, minute
// - Setup page applies address, time, alternate days
// - Device decodes and filters all page addressing
// - Backup power: relay and indicators off
// - Line return resumes last program relay state
// - Button forces relay until next step
// - Indicators: power, receiving, relay, address error
// - Flag no page since Saturday midnight
// - Show active plan kind and address
// - Addresses 01 to 99, switches or on-air
// - Search back after any download
package pts_pkg;
    localparam int          NSTEP      = 24;
    localparam int          IDX_W      = 5;
    localparam logic [1:0]  SLOT_DEF   = 2'h0;
    localparam logic [1:0]  SLOT_ALT   = 2'h1;
    localparam logic [1:0]  SLOT_OVR   = 2'h2;
    localparam logic [2:0]  DAY_SUN    = 3'h0;
    localparam logic [2:0]  DAY_SAT    = 3'h6;
    localparam logic [4:0]  HOUR_MAX   = 5'h17;
    localparam logic [5:0]  MIN_MAX    = 6'h3b;
    localparam logic [5:0]  SEC_MAX    = 6'h3b;
    localparam logic [6:0]  ADDR_MIN   = 7'h01;
    localparam logic [6:0]  ADDR_MAX   = 7'h63;
    localparam logic [6:0]  ADDR_RST   = 7'h00;
    localparam logic [7:0]  ALT_RST    = 8'h00;
    localparam int          CLK_HZ     = 250000000;
    localparam int          TICK_S     = 1;
    localparam int          SEC_CYCLES = CLK_HZ * TICK_S;

    typedef enum logic [3:0] {
        CMD_NONE       = 4'h0,
        CMD_DEF_STEP   = 4'h1,
        CMD_ALT_STEP   = 4'h2,
        CMD_OVR_STEP   = 4'h3,
        CMD_DEF_DONE   = 4'h4,
        CMD_ALT_DONE   = 4'h5,
        CMD_OVR_DONE   = 4'h6,
        CMD_OVR_CANCEL = 4'h7,
        CMD_ALT_CANCEL = 4'h8,
        CMD_TIME_SET   = 4'h9,
        CMD_SETUP      = 4'ha
    } pts_cmd_t;

    typedef enum logic [2:0] {
        ST_DEF = 3'b001,
        ST_ALT = 3'b010,
        ST_OVR = 3'b100
    } pts_sel_t;

    typedef enum logic [1:0] {
        PLAN_EMPTY = 2'h0,
        PLAN_DEF   = 2'h1,
        PLAN_ALT   = 2'h2,
        PLAN_OVR   = 2'h3
    } pts_plan_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic       on;
    } pts_step_t;

    typedef struct packed {
        logic [2:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
    } pts_tod_t;

    typedef struct packed {
        pts_cmd_t   cmd;
        logic [6:0] dst_group;
        logic [6:0] dst_loc;
        logic [IDX_W-1:0] index;
        pts_step_t  step;
        pts_tod_t   tod;
        logic       new_addr;
        logic [6:0] new_group;
        logic [6:0] new_loc;
        logic [7:0] alt_days;
    } pts_msg_t;

    localparam pts_tod_t TOD_RST = '{day: 3'h0, hour: 5'h00, minute: 6'h00};
endpackage : pts_pkg

// *** logic/pts_scheduler.sv ***
// Purpose: Time keeping, plan storage and relay selection for a paged time switch
// Assumes: Message port is on clk_i; panel and busy pins are asynchronous
// Notes:   Search back is continuous, so every download re-evaluates the relay
`timescale 1ns/1ps
`default_nettype none
module pts_scheduler
    import pts_pkg::*;
#(
    parameter int unsigned SEC_CYCLES_P = SEC_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Receiver message port
    input  wire logic       msg_valid_i,
    input  wire pts_msg_t   msg_i,
    input  wire logic       page_busy_i,
    // Panel pins
    input  wire logic       line_ok_i,
    input  wire logic       button_i,
    input  wire logic       addr_onair_i,
    input  wire logic [6:0] group_sw_i,
    input  wire logic [6:0] loc_sw_i,
    // Relay and indicators
    output logic            relay_o,
    output logic            led_power_o,
    output logic            led_rx_o,
    output logic            led_relay_o,
    output logic            led_addr_err_o,
    output logic            led_no_page_o,
    output pts_plan_t       plan_ind_o,
    output logic [6:0]      group_disp_o,
    output logic [6:0]      loc_disp_o
);
    localparam logic [27:0] DIV_LAST = 28'(SEC_CYCLES_P - 1);

    function automatic logic addr_ok(input logic [6:0] a);
        addr_ok = (a >= ADDR_MIN) && (a <= ADDR_MAX);
    endfunction : addr_ok

    function automatic logic [13:0] step_key(input pts_step_t s, input logic one_day,
                                             input logic [2:0] today);
        step_key = {(one_day ? today : s.day), s.hour, s.minute};
    endfunction : step_key

    // Synchronisers
    logic [1:0]  line_s_reg;
    logic [1:0]  busy_s_reg;
    logic [2:0]  btn_s_reg;
    logic [1:0]  mode_s_reg;
    logic [6:0]  grp_s1_reg;
    logic [6:0]  grp_s2_reg;
    logic [6:0]  loc_s1_reg;
    logic [6:0]  loc_s2_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_s_reg <= 2'h0;
            busy_s_reg <= 2'h0;
            btn_s_reg  <= 3'h0;
            mode_s_reg <= 2'h0;
            grp_s1_reg <= ADDR_RST;
            grp_s2_reg <= ADDR_RST;
            loc_s1_reg <= ADDR_RST;
            loc_s2_reg <= ADDR_RST;
        end else begin
            line_s_reg <= {line_s_reg[0], line_ok_i};
            busy_s_reg <= {busy_s_reg[0], page_busy_i};
            btn_s_reg  <= {btn_s_reg[1:0], button_i};
            mode_s_reg <= {mode_s_reg[0], addr_onair_i};
            grp_s1_reg <= group_sw_i;
            grp_s2_reg <= grp_s1_reg;
            loc_s1_reg <= loc_sw_i;
            loc_s2_reg <= loc_s1_reg;
        end
    end

    logic line_ok;
    logic btn_edge;
    logic onair;
    assign line_ok  = line_s_reg[1];
    assign btn_edge = btn_s_reg[1] & ~btn_s_reg[2];
    assign onair    = mode_s_reg[1];

    // Addressing and message acceptance
    logic [6:0] onair_grp_reg;
    logic [6:0] onair_loc_reg;
    logic [6:0] my_group;
    logic [6:0] my_loc;
    logic       addr_err;
    logic       acc;
    pts_cmd_t   cmd;

    assign my_group = onair ? onair_grp_reg : grp_s2_reg;
    assign my_loc   = onair ? onair_loc_reg : loc_s2_reg;
    assign addr_err = ~onair & ~(addr_ok(grp_s2_reg) & addr_ok(loc_s2_reg));
    // Location zero addresses the whole group
    assign acc = msg_valid_i && (msg_i.dst_group == my_group) &&
                 ((msg_i.dst_loc == my_loc) || (msg_i.dst_loc == ADDR_RST));
    assign cmd = msg_i.cmd;

    // Out-of-range on-air addresses are ignored, old address kept
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            onair_grp_reg <= ADDR_RST;
            onair_loc_reg <= ADDR_RST;
        end else if (acc && cmd == CMD_SETUP && msg_i.new_addr &&
                     addr_ok(msg_i.new_group) && addr_ok(msg_i.new_loc)) begin
            onair_grp_reg <= msg_i.new_group;
            onair_loc_reg <= msg_i.new_loc;
        end
    end

    // Seconds divider and time of day
    logic [27:0] div_reg;
    logic [5:0]  sec_reg;
    pts_tod_t    tod_reg;
    logic        tick;
    logic        time_load;
    logic        midnight;
    logic        week_roll;

    assign tick      = (div_reg == DIV_LAST);
    assign time_load = acc && (cmd == CMD_TIME_SET || cmd == CMD_SETUP);
    assign midnight  = tick && !time_load && sec_reg == SEC_MAX &&
                       tod_reg.minute == MIN_MAX && tod_reg.hour == HOUR_MAX;
    assign week_roll = midnight && tod_reg.day == DAY_SAT;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_reg <= 28'h0;
        end else if (tick) begin
            div_reg <= 28'h0;
        end else begin
            div_reg <= div_reg + 28'h1;
        end
    end

    // Keeps running on backup power
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_reg <= 6'h0;
            tod_reg <= TOD_RST;
        end else if (time_load) begin
            sec_reg <= 6'h0;
            tod_reg <= msg_i.tod;
        end else if (tick) begin
            sec_reg <= (sec_reg == SEC_MAX) ? 6'h0 : sec_reg + 6'h1;
            if (sec_reg == SEC_MAX) begin
                tod_reg.minute <= (tod_reg.minute == MIN_MAX) ? 6'h0 : tod_reg.minute + 6'h1;
                if (tod_reg.minute == MIN_MAX) begin
                    tod_reg.hour <= (tod_reg.hour == HOUR_MAX) ? 5'h0 : tod_reg.hour + 5'h1;
                    if (tod_reg.hour == HOUR_MAX) begin
                        tod_reg.day <= (tod_reg.day == DAY_SAT) ? DAY_SUN : tod_reg.day + 3'h1;
                    end
                end
            end
        end
    end

    // Plan store: slot per plan, writing step 0 discards the old plan
    pts_step_t  mem [3][NSTEP];
    logic [1:0] wr_slot;
    logic       wr_en;

    always_comb begin
        wr_slot = SLOT_DEF;
        wr_en   = 1'b0;
        case (cmd)
            CMD_DEF_STEP: begin
                wr_slot = SLOT_DEF;
                wr_en   = acc;
            end
            CMD_ALT_STEP: begin
                wr_slot = SLOT_ALT;
                wr_en   = acc;
            end
            CMD_OVR_STEP: begin
                wr_slot = SLOT_OVR;
                wr_en   = acc;
            end
            default: begin
                wr_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < 3; p++) begin
                for (int i = 0; i < NSTEP; i++) begin
                    mem[p][i] <= '0;
                end
            end
        end else if (wr_en && msg_i.index < IDX_W'(NSTEP)) begin
            if (msg_i.index == '0) begin
                for (int i = 1; i < NSTEP; i++) begin
                    mem[wr_slot][i].valid <= 1'b0;
                end
            end
            mem[wr_slot][msg_i.index] <= msg_i.step;
        end
    end

    // Active plan selection
    pts_sel_t   state_reg;
    logic       ret_alt_reg;
    logic [7:0] alt_left_reg;
    logic       alt_expire;

    // Zero days left means the alternate plan runs until cancelled
    assign alt_expire = midnight && alt_left_reg == 8'h01;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alt_left_reg <= ALT_RST;
        end else if (acc && (cmd == CMD_ALT_DONE || cmd == CMD_SETUP)) begin
            alt_left_reg <= msg_i.alt_days;
        end else if (midnight && alt_left_reg != 8'h00) begin
            alt_left_reg <= alt_left_reg - 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= ST_DEF;
            ret_alt_reg <= 1'b0;
        end else if (acc) begin
            case (cmd)
                CMD_DEF_DONE: state_reg <= ST_DEF;
                CMD_ALT_DONE: state_reg <= ST_ALT;
                CMD_SETUP: state_reg <= (msg_i.alt_days != 8'h00) ? ST_ALT : ST_DEF;
                CMD_OVR_DONE: begin
                    if (state_reg != ST_OVR) begin
                        ret_alt_reg <= (state_reg == ST_ALT);
                    end
                    state_reg <= ST_OVR;
                end
                CMD_OVR_CANCEL: begin
                    if (state_reg == ST_OVR) begin
                        state_reg <= ret_alt_reg ? ST_ALT : ST_DEF;
                    end
                end
                CMD_ALT_CANCEL: begin
                    if (state_reg == ST_ALT) begin
                        state_reg <= ST_DEF;
                    end
                    ret_alt_reg <= 1'b0;
                end
                default: ;
            endcase
        end else if (midnight) begin
            case (state_reg)
                ST_ALT: begin
                    if (alt_expire) begin
                        state_reg <= ST_DEF;
                    end
                end
                ST_OVR: begin
                    state_reg <= (ret_alt_reg && !alt_expire) ? ST_ALT : ST_DEF;
                end
                default: ;
            endcase
        end
    end

    // Search back over the active plan
    logic [1:0]  rd_slot;
    logic [13:0] now_key;
    logic [13:0] k;
    logic        hit;
    logic [13:0] hit_key;
    logic        hit_on;
    logic        top;
    logic [13:0] top_key;
    logic        top_on;
    logic        sched_on;
    logic [13:0] sched_key;
    logic        is_ovr;

    assign is_ovr  = (state_reg == ST_OVR);
    assign rd_slot = is_ovr ? SLOT_OVR : (state_reg == ST_ALT) ? SLOT_ALT : SLOT_DEF;
    assign now_key = {tod_reg.day, tod_reg.hour, tod_reg.minute};

    // Week plans wrap to last week's final step; override has no carry-in
    always_comb begin
        k       = 14'h0;
        hit     = 1'b0;
        hit_key = 14'h0;
        hit_on  = 1'b0;
        top     = 1'b0;
        top_key = 14'h0;
        top_on  = 1'b0;
        for (int i = 0; i < NSTEP; i++) begin
            k = step_key(mem[rd_slot][i], is_ovr, tod_reg.day);
            if (mem[rd_slot][i].valid) begin
                if (k <= now_key && (!hit || k >= hit_key)) begin
                    hit     = 1'b1;
                    hit_key = k;
                    hit_on  = mem[rd_slot][i].on;
                end
                if (!top || k >= top_key) begin
                    top     = 1'b1;
                    top_key = k;
                    top_on  = mem[rd_slot][i].on;
                end
            end
        end
        sched_on  = hit ? hit_on : (top && !is_ovr && top_on);
        sched_key = hit ? hit_key : top_key;
    end

    // Manual override of the relay
    logic [13:0] key_q_reg;
    pts_sel_t    sel_q_reg;
    logic        step_change;
    logic        man_act_reg;
    logic        man_val_reg;
    logic        relay_state;

    assign step_change = (sched_key != key_q_reg) || (state_reg != sel_q_reg);
    assign relay_state = man_act_reg ? man_val_reg : sched_on;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_q_reg <= 14'h0;
            sel_q_reg <= ST_DEF;
        end else begin
            key_q_reg <= sched_key;
            sel_q_reg <= state_reg;
        end
    end

    // A press in the same cycle as a step boundary still takes effect
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            man_act_reg <= 1'b0;
            man_val_reg <= 1'b0;
        end else if (btn_edge && line_ok) begin
            man_act_reg <= 1'b1;
            man_val_reg <= ~relay_state;
        end else if (step_change) begin
            man_act_reg <= 1'b0;
        end
    end

    // Missed weekly page
    logic page_seen_reg;
    logic no_page_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            page_seen_reg <= 1'b0;
            no_page_reg   <= 1'b0;
        end else begin
            page_seen_reg <= week_roll ? acc : (page_seen_reg | acc);
            if (week_roll && !page_seen_reg) begin
                no_page_reg <= 1'b1;
            end else if (acc) begin
                no_page_reg <= 1'b0;
            end
        end
    end

    // Outputs: dark on backup, program state returns with line power
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            relay_o        <= 1'b0;
            led_power_o    <= 1'b0;
            led_rx_o       <= 1'b0;
            led_relay_o    <= 1'b0;
            led_addr_err_o <= 1'b0;
            led_no_page_o  <= 1'b0;
            plan_ind_o     <= PLAN_EMPTY;
            group_disp_o   <= ADDR_RST;
            loc_disp_o     <= ADDR_RST;
        end else if (!line_ok) begin
            relay_o        <= 1'b0;
            led_power_o    <= 1'b0;
            led_rx_o       <= 1'b0;
            led_relay_o    <= 1'b0;
            led_addr_err_o <= 1'b0;
            led_no_page_o  <= 1'b0;
            plan_ind_o     <= PLAN_EMPTY;
            group_disp_o   <= ADDR_RST;
            loc_disp_o     <= ADDR_RST;
        end else begin
            relay_o        <= relay_state;
            led_power_o    <= 1'b1;
            led_rx_o       <= busy_s_reg[1];
            led_relay_o    <= relay_state;
            led_addr_err_o <= addr_err;
            led_no_page_o  <= no_page_reg;
            plan_ind_o     <= is_ovr ? PLAN_OVR : (state_reg == ST_ALT) ? PLAN_ALT :
                              (mem[SLOT_DEF][0].valid ? PLAN_DEF : PLAN_EMPTY);
            group_disp_o   <= my_group;
            loc_disp_o     <= my_loc;
        end
    end

    // Checks
    AST_TIME_SET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (acc && cmd == CMD_TIME_SET) |=> (tod_reg == $past(msg_i.tod) && sec_reg == 6'h0))
        else $error("time set page not loaded");
    AST_DEF_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (acc && cmd == CMD_DEF_DONE) |=> state_reg == ST_DEF)
        else $error("default plan not started");
    AST_ALT_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (acc && cmd == CMD_ALT_DONE) |=> ##1 (!$past(line_ok) || plan_ind_o == PLAN_ALT || is_ovr))
        else $error("alternate plan not shown running");
    AST_OVR_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (acc && cmd == CMD_OVR_DONE && line_ok) |=> ##1 (!$past(line_ok) || plan_ind_o == PLAN_OVR))
        else $error("override plan not started");
    AST_OVR_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (is_ovr && midnight && !acc) |=> (state_reg == ($past(ret_alt_reg) &&
            !$past(alt_expire) ? ST_ALT : ST_DEF)))
        else $error("override not ended at midnight");
    AST_BACKUP_DARK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !line_ok |=> (!relay_o && !led_power_o && !led_relay_o && !led_no_page_o))
        else $error("outputs lit on backup power");
    AST_RELAY_SEARCH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (line_ok && !man_act_reg) |=> relay_o == $past(sched_on))
        else $error("relay differs from searched step");
    AST_MANUAL_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (btn_edge && line_ok) |=> (man_act_reg && man_val_reg == !$past(relay_state)))
        else $error("button did not force relay");
    AST_ADDR_ERR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (line_ok && !onair && (grp_s2_reg == ADDR_RST || grp_s2_reg > ADDR_MAX)) |=> led_addr_err_o)
        else $error("address error not indicated");
    AST_NO_PAGE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (week_roll && !page_seen_reg) |=> no_page_reg ##1 (no_page_reg || $past(acc)))
        else $error("missed page flag not raised");

    COV_OVERRIDE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        (acc && cmd == CMD_OVR_DONE) ##[1:1000] !is_ovr);
    COV_MANUAL: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        man_act_reg ##1 !man_act_reg);
    COV_ALT_EXPIRE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_ALT && alt_expire));
endmodule : pts_scheduler
`default_nettype wire

// *** bench/pts_pager_model.sv ***
// Purpose: Paging receiver stand-in handing decoded pages to the scheduler
// Assumes: Pages already passed the receiver's own page code filter
// Notes:   Message lines carry inverted junk between pages
`timescale 1ns/1ps
`default_nettype none
module pts_pager_model
    import pts_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // Message port
    output logic      msg_valid_o,
    output pts_msg_t  msg_o,
    output logic      page_busy_o
);
    initial begin
        msg_valid_o = 1'b0;
        msg_o       = '0;
        page_busy_o = 1'b0;
    end
    // Address filtering is left to the scheduler
    task automatic send(input pts_msg_t m);
        @(posedge clk_i) #1;
        page_busy_o = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        msg_o       = m;
        msg_valid_o = 1'b1;
        @(posedge clk_i) #1;
        msg_valid_o = 1'b0;
        msg_o       = ~m;
        page_busy_o = 1'b0;
    endtask : send
endmodule : pts_pager_model
`default_nettype wire

// *** bench/pts_scheduler_bench.sv ***
// Purpose: Self-checking bench for the paged time switch scheduler
// Assumes: One second tick every 2 clocks, so a minute is 120 cycles
// Notes:   Checks land 3 edges after a page, outputs lag by 2
`timescale 1ns/1ps
`default_nettype none
module pts_scheduler_bench;
    import pts_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       mv;
    pts_msg_t   mi;
    logic       busy;
    logic       line_ok = 1'b0;
    logic       button = 1'b0;
    logic       onair = 1'b0;
    logic [6:0] gsw = 7'h05;
    logic [6:0] lsw = 7'h07;
    logic       relay, l_pwr, l_rx, l_rel, l_err, l_np;
    pts_plan_t  plan;
    logic [6:0] gdisp, ldisp;
    pts_msg_t   m;
    int         bad_count = 0;
    int         samples_checked = 0;
    always #2 clk = ~clk;
    pts_pager_model i_pager (.clk_i(clk), .msg_valid_o(mv), .msg_o(mi), .page_busy_o(busy));
    pts_scheduler #(.SEC_CYCLES_P(2)) i_dut (
        .clk_i(clk), .rst_n_i(rst_n), .msg_valid_i(mv), .msg_i(mi), .page_busy_i(busy),
        .line_ok_i(line_ok), .button_i(button), .addr_onair_i(onair), .group_sw_i(gsw),
        .loc_sw_i(lsw), .relay_o(relay), .led_power_o(l_pwr), .led_rx_o(l_rx),
        .led_relay_o(l_rel), .led_addr_err_o(l_err), .led_no_page_o(l_np),
        .plan_ind_o(plan), .group_disp_o(gdisp), .loc_disp_o(ldisp));
    task automatic chk(input string what, input logic [7:0] seen, input int exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    function automatic pts_msg_t mk(pts_cmd_t c, int i, int d, int h, int mn, int on);
        pts_msg_t r;
        r = '0;
        r.cmd = c;
        r.dst_group = 7'h05;
        r.dst_loc = 7'h07;
        r.index = 5'(i);
        r.step = '{valid: 1'b1, day: 3'(d), hour: 5'(h), minute: 6'(mn), on: 1'(on)};
        r.tod = '{day: 3'(d), hour: 5'(h), minute: 6'(mn)};
        r.alt_days = 8'h02;
        return r;
    endfunction : mk
    task automatic see(input logic r, input pts_plan_t p);
        cyc(3);
        chk("relay", relay, r);
        chk("led_relay", l_rel, r);
        chk("plan_ind", plan, p);
        chk("led_rx", l_rx, 0);
    endtask : see
    task automatic put(input pts_msg_t x);
        i_pager.send(x);
    endtask : put
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'b1;
        line_ok = 1'b1;
        cyc(5);
        see(1'b0, PLAN_EMPTY);
        chk("power", l_pwr, 1);
        chk("group", gdisp, 5);
        chk("loc", ldisp, 7);
        chk("no_page", l_np, 0);
        $display("Test reset done");
        put(mk(CMD_TIME_SET, 0, 1, 10, 0, 0));
        chk("led_rx_busy", l_rx, 1);
        put(mk(CMD_DEF_STEP, 0, 1, 8, 0, 1));
        put(mk(CMD_DEF_STEP, 1, 1, 12, 0, 0));
        put(mk(CMD_DEF_STEP, 5'h18, 1, 9, 0, 0));
        put(mk(CMD_DEF_DONE, 0, 0, 0, 0, 0));
        see(1'b1, PLAN_DEF);
        put(mk(CMD_ALT_STEP, 0, 1, 9, 0, 0));
        put(mk(CMD_ALT_DONE, 0, 0, 0, 0, 0));
        see(1'b0, PLAN_ALT);
        put(mk(CMD_OVR_STEP, 0, 0, 0, 0, 1));
        put(mk(CMD_OVR_DONE, 0, 0, 0, 0, 0));
        see(1'b1, PLAN_OVR);
        $display("Test plans done");
        line_ok = 1'b0;
        cyc(5);
        chk("relay_backup", relay, 0);
        chk("power_backup", l_pwr, 0);
        chk("group_backup", gdisp, 0);
        line_ok = 1'b1;
        cyc(2);
        see(1'b1, PLAN_OVR);
        put(mk(CMD_OVR_CANCEL, 0, 0, 0, 0, 0));
        see(1'b0, PLAN_ALT);
        m = mk(CMD_OVR_DONE, 0, 0, 0, 0, 0);
        m.dst_group = 7'h06;
        put(m);
        see(1'b0, PLAN_ALT);
        button = 1'b1;
        cyc(5);
        button = 1'b0;
        chk("relay_button", relay, 1);
        $display("Test power and button done");
        put(mk(CMD_OVR_DONE, 0, 0, 0, 0, 0));
        put(mk(CMD_TIME_SET, 0, 1, 23, 59, 0));
        see(1'b1, PLAN_OVR);
        cyc(125);
        see(1'b0, PLAN_ALT);
        put(mk(CMD_TIME_SET, 0, 2, 23, 59, 0));
        cyc(125);
        see(1'b0, PLAN_DEF);
        $display("Test midnight done");
        gsw = 7'h64;
        cyc(5);
        chk("addr_err", l_err, 1);
        gsw = 7'h05;
        m = mk(CMD_SETUP, 0, 1, 10, 0, 0);
        m.new_addr = 1'b1;
        m.new_group = 7'h09;
        m.new_loc = 7'h03;
        m.alt_days = 8'h00;
        put(m);
        onair = 1'b1;
        see(1'b1, PLAN_DEF);
        cyc(3);
        chk("group_air", gdisp, 9);
        chk("loc_air", ldisp, 3);
        $display("Test setup done");
        complete_run();
    end
endmodule : pts_scheduler_bench
`default_nettype wire
